/* shutter_ctrl_regs.svh */
`ifndef SHUTTER_CTRL_REGS_SVH
`define SHUTTER_CTRL_REGS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SC_ADDR_CTRL 12'h000
`define SC_ADDR_STATUS 12'h004
`define SC_CTRL_RESET 4'h0
`define SC_CTRL_POS_MSB 3
`define SC_ST_ASYNC 0
`define SC_ST_MEMVALID 1
`define SC_ST_STATE_LSB 2
`define SC_ST_STATE_MSB 3
`define SC_ST_CAPT_LSB 8
`define SC_ST_CAPT_MSB 15
// ----------------------------------------
// Selector positions
// ----------------------------------------
`define SC_POS_NORMAL 4'h0
`define SC_POS_FAST_LAST 4'h4
`define SC_POS_SLOW_LAST 4'h8
`define SC_POS_PULSE 4'h9
`define SC_POS_FIRST 4'h1
// ----------------------------------------
// Line timing
// ----------------------------------------
`define SC_PW_DELAY_H 4'h9
`define SC_LINE_RATE_HZ 15750
`define SC_FRAME_RATE_HZ 15
`define SC_LINES_PER_FRAME 11'(`SC_LINE_RATE_HZ / `SC_FRAME_RATE_HZ)
`define SC_LINE_LAST (`SC_LINES_PER_FRAME - 11'h001)
`define SC_ACTIVE_LINES 11'h400
`define SC_EXP_ONE 8'h01
`endif

/* shutter_ctrl_pkg.sv */
package shutter_ctrl_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_PW_LOW, ST_EXPOSE} state_t;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_FAST, MODE_SLOW, MODE_PULSE} mode_t;
	typedef struct packed {
		logic vsync;
		logic frame_valid;
		logic line_start;
		logic black;
		logic live;
	} video_t;
	typedef struct packed {
		logic discharge;
		logic integrate;
		logic frame_write;
		logic marker;
	} sensor_t;
endpackage : shutter_ctrl_pkg

/* async_reset_shutter_control.sv */
// Notes on behaviour
// - Line timing follows the external line drive, which must run continuously.
// - Exposure comes from an external pulse width or the ten-position selector.
// - Asynchronous shutter only with the select strap open, using external line drive.
// - A falling reset edge is held until the next line drive pulse.
// - At that point vertical timing restarts; line timing keeps its phase.
// - Each accepted reset overwrites frame memory; frames replay progressively.
// - Selector position 9 selects external pulse-width exposure.
// - Pulse-width: discharge ends at the ninth line drive after the falling edge.
// - Pulse-width: the rising edge makes the internal reset, restarting vertical timing.
// - Pulse-width: exposure equals pulse low time, starting nine lines late.
// - Pulse-width: one progressive frame starts at the rising edge.
// - With reset input high, the stored image repeats until the next trigger.
// - Trigger held high in asynchronous mode: continuous discharge, black video until a frame is stored.
// - Positions 1 to 4: fast reset latched to line drive, selector sets exposure.
// - Fast mode: video starts with the internal reset, no extra delay.
// - Positions 5 to 8: first reset latched, second reset ends exposure.
// - Slow mode: video starts right after the second internal reset.
// - A marker pulse shows the time of the second internal reset.
// - Frames replay at 15 frames per second.
// - The old frame keeps playing during a long integration.
// - Normal selection gives live video with manual exposure.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "shutter_ctrl_regs.svh"
module async_reset_shutter_control (
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	// Trigger, line drive and strap
	input wire logic ASYNC_RESET_INPUT_IN,
	input wire logic LINE_DRIVE_REFERENCE_IN,
	input wire logic ASYNC_SELECT_STRAP_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic PREADY_OUT,
	output logic [31:0] PRDATA_OUT,
	output logic PSLVERR_OUT,
	// Sensor control
	output logic DISCHARGE_OUT,
	output logic INTEGRATE_OUT,
	output logic FRAME_WRITE_OUT,
	output logic SECOND_RESET_MARKER_OUT,
	// Video timing
	output logic VSYNC_OUT,
	output logic FRAME_VALID_OUT,
	output logic LINE_START_OUT,
	output logic VIDEO_BLACK_OUT,
	output logic VIDEO_LIVE_OUT
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic trig_s1, trig_s2, trig_s3;
	logic hd_s1, hd_s2, hd_s3;
	logic trig_fall, trig_rise, hd;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			trig_s1 <= 1'b1;
			trig_s2 <= 1'b1;
			trig_s3 <= 1'b1;
			hd_s1 <= 1'b0;
			hd_s2 <= 1'b0;
			hd_s3 <= 1'b0;
		end else if (CE_IN) begin
			// First stage feeds only the second: metastability stays out of the edge logic
			trig_s1 <= ASYNC_RESET_INPUT_IN;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
			hd_s1 <= LINE_DRIVE_REFERENCE_IN;
			hd_s2 <= hd_s1;
			hd_s3 <= hd_s2;
		end
	end

	assign trig_fall = trig_s3 & ~trig_s2;
	assign trig_rise = ~trig_s3 & trig_s2;
	// Every line event comes from the external drive, so no internal line counter drifts
	assign hd = hd_s2 & ~hd_s3;

	// ----------------------------------------
	// Registers and mode decode
	// ----------------------------------------
	logic [3:0] pos;
	logic async_on;
	logic mem_valid;
	logic [7:0] capt_cnt;
	shutter_ctrl_pkg::mode_t mode;
	shutter_ctrl_pkg::state_t st, next_st;

	always_comb begin
		if (pos == `SC_POS_PULSE)
			mode = shutter_ctrl_pkg::MODE_PULSE;
		else if (pos > `SC_POS_FAST_LAST)
			mode = shutter_ctrl_pkg::MODE_SLOW;
		else if (pos != `SC_POS_NORMAL)
			mode = shutter_ctrl_pkg::MODE_FAST;
		else
			mode = shutter_ctrl_pkg::MODE_NORMAL;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			async_on <= 1'b0;
		end else if (CE_IN) begin
			async_on <= ASYNC_SELECT_STRAP_IN && (pos != `SC_POS_NORMAL);
		end
	end

	// Selector positions 1..8 give 1, 2, 4 .. 128 lines
	function automatic logic [7:0] exp_lines(input logic [3:0] p);
		logic [3:0] sh;
		sh = p - `SC_POS_FIRST;
		exp_lines = `SC_EXP_ONE << sh[2:0];
	endfunction : exp_lines

	// ----------------------------------------
	// Shutter sequencer
	// ----------------------------------------
	logic [7:0] cnt, next_cnt;
	logic [3:0] hcnt, next_hcnt;
	logic restart, capture, marker;

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_hcnt = hcnt;
		restart = 1'b0;
		capture = 1'b0;
		marker = 1'b0;
		if (!async_on) begin
			next_st = shutter_ctrl_pkg::ST_IDLE;
		end else begin
			case (st)
				shutter_ctrl_pkg::ST_IDLE: begin
					if (trig_fall)
						next_st = shutter_ctrl_pkg::ST_PEND;
				end
				shutter_ctrl_pkg::ST_PEND: begin
					if (mode == shutter_ctrl_pkg::MODE_PULSE && trig_rise) begin
						// Pulse shorter than a line: capture with no integration
						capture = 1'b1;
						restart = 1'b1;
						next_st = shutter_ctrl_pkg::ST_IDLE;
					end else if (hd) begin
						restart = 1'b1;
						if (mode == shutter_ctrl_pkg::MODE_PULSE) begin
							next_hcnt = `SC_POS_FIRST;
							next_st = shutter_ctrl_pkg::ST_PW_LOW;
						end else begin
							next_cnt = exp_lines(pos);
							next_st = shutter_ctrl_pkg::ST_EXPOSE;
						end
					end
				end
				shutter_ctrl_pkg::ST_PW_LOW: begin
					if (trig_rise) begin
						capture = 1'b1;
						restart = 1'b1;
						next_st = shutter_ctrl_pkg::ST_IDLE;
					end else if (hd && hcnt != `SC_PW_DELAY_H) begin
						next_hcnt = hcnt + `SC_POS_FIRST;
					end
				end
				shutter_ctrl_pkg::ST_EXPOSE: begin
					if (hd) begin
						if (cnt == `SC_EXP_ONE) begin
							capture = 1'b1;
							next_st = shutter_ctrl_pkg::ST_IDLE;
							if (mode == shutter_ctrl_pkg::MODE_SLOW) begin
								marker = 1'b1;
								restart = 1'b1;
							end
						end else begin
							next_cnt = cnt - `SC_EXP_ONE;
						end
					end
				end
				default: begin
					next_st = shutter_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			st <= shutter_ctrl_pkg::ST_IDLE;
			cnt <= 8'h00;
			hcnt <= 4'h0;
		end else if (CE_IN) begin
			st <= next_st;
			cnt <= next_cnt;
			hcnt <= next_hcnt;
		end
	end

	// ----------------------------------------
	// Sensor and memory control
	// ----------------------------------------
	shutter_ctrl_pkg::sensor_t sen, next_sen;
	logic next_mem_valid;
	logic [10:0] line_cnt, next_line;

	always_comb begin
		next_sen = '0;
		next_mem_valid = async_on && (mem_valid || capture);
		if (async_on) begin
			// Idle or waiting: keep draining the well so no stray charge builds up
			next_sen.discharge = (next_st == shutter_ctrl_pkg::ST_IDLE)
				|| (next_st == shutter_ctrl_pkg::ST_PEND)
				|| (next_st == shutter_ctrl_pkg::ST_PW_LOW
				&& next_hcnt != `SC_PW_DELAY_H);
			next_sen.integrate = (next_st == shutter_ctrl_pkg::ST_EXPOSE)
				|| (next_st == shutter_ctrl_pkg::ST_PW_LOW
				&& next_hcnt == `SC_PW_DELAY_H);
		end else begin
			next_sen.integrate = 1'b1;
		end
		// Memory is overwritten from a capture until the current frame ends
		next_sen.frame_write = capture || (sen.frame_write && !(hd && line_cnt == `SC_LINE_LAST));
		next_sen.marker = marker;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sen <= '0;
			mem_valid <= 1'b0;
			capt_cnt <= 8'h00;
		end else if (CE_IN) begin
			sen <= next_sen;
			mem_valid <= next_mem_valid;
			if (capture)
				capt_cnt <= capt_cnt + `SC_EXP_ONE;
		end
	end

	assign DISCHARGE_OUT = sen.discharge;
	assign INTEGRATE_OUT = sen.integrate;
	assign FRAME_WRITE_OUT = sen.frame_write;
	assign SECOND_RESET_MARKER_OUT = sen.marker;

	// ----------------------------------------
	// Vertical timing and replay
	// ----------------------------------------
	shutter_ctrl_pkg::video_t vid, next_vid;

	always_comb begin
		next_line = line_cnt;
		if (restart)
			next_line = 11'h000;
		else if (hd)
			next_line = (line_cnt == `SC_LINE_LAST) ? 11'h000 : line_cnt + 11'h001;
		next_vid.vsync = restart || (hd && line_cnt == `SC_LINE_LAST);
		next_vid.frame_valid = next_line < `SC_ACTIVE_LINES;
		// Line starts stay on the external drive through a restart
		next_vid.line_start = hd;
		// Old image keeps playing while a new one integrates; black only when none held
		next_vid.black = async_on && !next_mem_valid;
		next_vid.live = !async_on;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			line_cnt <= 11'h000;
			vid <= '0;
		end else if (CE_IN) begin
			line_cnt <= next_line;
			vid <= next_vid;
		end
	end

	assign VSYNC_OUT = vid.vsync;
	assign FRAME_VALID_OUT = vid.frame_valid;
	assign LINE_START_OUT = vid.line_start;
	assign VIDEO_BLACK_OUT = vid.black;
	assign VIDEO_LIVE_OUT = vid.live;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic pready, pslverr;
	logic [31:0] prdata, rd;
	logic hit_ctrl, hit_stat, done;

	assign hit_ctrl = PADDR_IN == `SC_ADDR_CTRL;
	assign hit_stat = PADDR_IN == `SC_ADDR_STATUS;
	assign done = PSEL_IN && PENABLE_IN && pready;

	always_comb begin
		rd = 32'h0000_0000;
		if (hit_ctrl) begin
			rd[`SC_CTRL_POS_MSB:0] = pos;
		end else if (hit_stat) begin
			rd[`SC_ST_ASYNC] = async_on;
			rd[`SC_ST_MEMVALID] = mem_valid;
			rd[`SC_ST_STATE_MSB:`SC_ST_STATE_LSB] = st;
			rd[`SC_ST_CAPT_MSB:`SC_ST_CAPT_LSB] = capt_cnt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (CE_IN) begin
			// One wait state keeps read data and error straight from flip-flops
			pready <= PSEL_IN && PENABLE_IN && !pready;
			prdata <= rd;
			pslverr <= PSEL_IN && PENABLE_IN && !pready && !hit_ctrl && !hit_stat;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			pos <= `SC_CTRL_RESET;
		end else if (CE_IN) begin
			// Only ten positions exist; values above 9 are dropped
			if (done && PWRITE_IN && hit_ctrl && PWDATA_IN[3:0] <= `SC_POS_PULSE)
				pos <= PWDATA_IN[3:0];
		end
	end

	assign PREADY_OUT = pready;
	assign PRDATA_OUT = prdata;
	assign PSLVERR_OUT = pslverr;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_fall_pending: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_IDLE && trig_fall
		|=> st == shutter_ctrl_pkg::ST_PEND)
		else $error("falling trigger not held for line drive");

	a_latch_restart: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_PEND && hd && !trig_rise
		|=> line_cnt == 11'h000 && VSYNC_OUT && LINE_START_OUT)
		else $error("vertical timing not restarted at latched line");

	a_idle_discharge: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_IDLE && !mem_valid
		|=> DISCHARGE_OUT && !INTEGRATE_OUT && VIDEO_BLACK_OUT)
		else $error("idle async not discharging black");

	a_ninth_line: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_PW_LOW && hd && !trig_rise
		&& hcnt == 4'h8 |=> !DISCHARGE_OUT && INTEGRATE_OUT)
		else $error("discharge not ended at ninth line drive");

	a_rise_capture: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_PW_LOW && trig_rise
		|=> FRAME_WRITE_OUT && line_cnt == 11'h000 && FRAME_VALID_OUT && DISCHARGE_OUT)
		else $error("rising edge did not capture and restart");

	a_slow_marker: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_EXPOSE && hd && cnt == 8'h01
		&& mode == shutter_ctrl_pkg::MODE_SLOW
		|=> SECOND_RESET_MARKER_OUT && line_cnt == 11'h000 ##1 !SECOND_RESET_MARKER_OUT)
		else $error("second reset marker missing");

	a_fast_expose: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && st == shutter_ctrl_pkg::ST_PEND && hd && pos == 4'h2
		&& !trig_rise |=> INTEGRATE_OUT && cnt == 8'h02)
		else $error("fast exposure length wrong");

	a_replay_held: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && async_on && mem_valid |=> !VIDEO_BLACK_OUT)
		else $error("stored frame not replayed");

	a_live_normal: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && !async_on |=> VIDEO_LIVE_OUT && !DISCHARGE_OUT && !VIDEO_BLACK_OUT)
		else $error("normal mode not live");

	a_frame_wrap: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && hd && !restart && line_cnt == `SC_LINE_LAST |=> line_cnt == 11'h000 && VSYNC_OUT)
		else $error("frame length not 1050 lines");
endmodule : async_reset_shutter_control

/* line_trigger_source.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Far side: line drive and trigger source
// ----------------------------------------
module line_trigger_source #(
	parameter int LINE_PERIOD = 10
) (
	// Clock
	input wire logic clk_in,
	// Trigger request, high = hold trigger low
	input wire logic trig_low_in,
	// Pins
	output logic line_drive_out,
	output logic trigger_out
);
	logic [7:0] cnt = 8'h00;
	initial line_drive_out = 1'b0;
	initial trigger_out = 1'b1;
	// Runs free, even through reset, so the lock never loses its reference
	always @(posedge clk_in) begin
		cnt <= (cnt == 8'(LINE_PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
		line_drive_out <= (cnt < 8'h03);
	end
	// Trigger idles high, active-low pulse
	always @(posedge clk_in) begin
		trigger_out <= ~trig_low_in;
	end
endmodule : line_trigger_source

/* async_reset_shutter_control_test.sv */
`timescale 1ns/1ps
`include "shutter_ctrl_regs.svh"
module async_reset_shutter_control_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b0;
	logic ce = 1'b1;
	logic trig_low = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] seed = 32'h00006868;
	logic [3:0] ctrl = 4'h0;
	logic pready, pslverr, line_drive, trigger, discharge, integrate, frame_write, marker;
	logic vsync, frame_valid, line_start, black, live;
	int n_fail = 0;
	int total_checks = 0;

	always #20 clk = ~clk;

	line_trigger_source #(.LINE_PERIOD(10)) far_end (.clk_in(clk), .trig_low_in(trig_low),
		.line_drive_out(line_drive), .trigger_out(trigger));

	async_reset_shutter_control uut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.ASYNC_RESET_INPUT_IN(trigger), .LINE_DRIVE_REFERENCE_IN(line_drive),
		.ASYNC_SELECT_STRAP_IN(strap), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
		.PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .DISCHARGE_OUT(discharge),
		.INTEGRATE_OUT(integrate), .FRAME_WRITE_OUT(frame_write),
		.SECOND_RESET_MARKER_OUT(marker), .VSYNC_OUT(vsync), .FRAME_VALID_OUT(frame_valid),
		.LINE_START_OUT(line_start), .VIDEO_BLACK_OUT(black), .VIDEO_LIVE_OUT(live));

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [3:0] exp_ctrl(input logic [3:0] old, input logic [3:0] wr);
		return (wr > `SC_POS_PULSE) ? old : wr;
	endfunction : exp_ctrl

	function automatic int exp_lines(input int p);
		return (p <= 4) ? (1 << (p - 1)) : (16 << (p - 5));
	endfunction : exp_lines

	function automatic logic hit(input int w);
		case (w)
			0: return vsync === 1'b1;
			1: return frame_write === 1'b1;
			2: return marker === 1'b1;
			3: return discharge === 1'b0;
			default: return frame_write === 1'b0;
		endcase
	endfunction : hit

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int c;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (c = 0; c < 20; c++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", 32'(c < 20), 32'h1);
	endtask : apb

	// Counts line starts until the chosen condition is seen; -1 on a hang
	task automatic measure(input int w, output int n);
		int c;
		n = 0;
		for (c = 0; c < 15000; c++) begin
			@(posedge clk);
			if (line_start === 1'b1) n++;
			if (hit(w)) break;
		end
		if (c == 15000) n = -1;
	endtask : measure

	// Falls just after a line start so the next line edge is the latch point
	task automatic trig_fall();
		int c;
		for (c = 0; c < 40; c++) begin
			@(posedge clk);
			if (line_start === 1'b1) break;
		end
		trig_low <= 1'b1;
	endtask : trig_fall

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		int n;
		logic [31:0] rd;
		logic [31:0] v;
		logic err;
		repeat (2) @(posedge clk);
		check("reset_live", live, 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check("live", live, 32'h1);
		check("integrate", integrate, 32'h1);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'h0000000a : xs();
			apb(1'b1, `SC_ADDR_CTRL, {28'h0000000, v[3:0]}, rd, err);
			ctrl = exp_ctrl(ctrl, v[3:0]);
			apb(1'b0, `SC_ADDR_CTRL, 32'h00000000, rd, err);
			check("ctrl", rd, {28'h0000000, ctrl});
		end
		apb(1'b0, 12'h008, 32'h00000000, rd, err);
		check("unmapped_err", err, 32'h1);
		check("unmapped_data", rd, 32'h0);
		apb(1'b0, `SC_ADDR_STATUS, 32'h00000000, rd, err);
		check("async_off", rd[0], 32'h0);
		apb(1'b1, `SC_ADDR_CTRL, 32'(`SC_POS_PULSE), rd, err);
		// Strap opens while the enable is low: nothing may move until it returns
		strap <= 1'b1;
		ce <= 1'b0;
		repeat (6) @(posedge clk);
		check("ce_frozen", live, 32'h1);
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		check("black_idle", black, 32'h1);
		check("discharge_idle", discharge, 32'h1);
		apb(1'b0, `SC_ADDR_STATUS, 32'h00000000, rd, err);
		check("async_on", rd[0], 32'h1);
		trig_fall();
		measure(0, n);
		check("latch_lines", n, 32'h1);
		measure(3, n);
		check("discharge_lines", n, 32'h8);
		v = xs();
		repeat (5 + v[5:0]) @(posedge clk);
		check("integrate_pw", integrate, 32'h1);
		trig_low <= 1'b0;
		// Checked at the vsync edge so a line start just after it still counts
		measure(0, n);
		check("capture", frame_write, 32'h1);
		check("discharge_after", discharge, 32'h1);
		check("integrate_end", integrate, 32'h0);
		check("black_after", black, 32'h0);
		measure(0, n);
		check("frame_lines", n, 32'h41a);
		check("replay", black, 32'h0);
		apb(1'b0, `SC_ADDR_STATUS, 32'h00000000, rd, err);
		check("stored", rd[1], 32'h1);
		check("captures", rd[15:8], 32'h1);
		for (int p = 1; p <= 8; p++) begin
			apb(1'b1, `SC_ADDR_CTRL, 32'(p), rd, err);
			if (p <= 4) measure(4, n);
			trig_fall();
			measure(0, n);
			trig_low <= 1'b0;
			measure((p <= 4) ? 1 : 2, n);
			check("exposure_lines", n, 32'(exp_lines(p)));
			if (p > 4) check("slow_restart", vsync, 32'h1);
		end
		apb(1'b0, `SC_ADDR_STATUS, 32'h00000000, rd, err);
		check("captures_all", rd[15:8], 32'h9);
		strap <= 1'b0;
		repeat (4) @(posedge clk);
		check("live_back", live, 32'h1);
		report_and_stop();
	end

	// Whole run needs about 45000 cycles
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		$display("[ERR] watchdog expected done seen hang");
		report_and_stop();
	end
endmodule : async_reset_shutter_control_test
